// ==== core/ivp_pkg.sv ====
// Package for the interrupt vector and priority block
package ivp_pkg;
  // Control register field positions and reset value
  localparam int CTL_EN0_BIT = 0;
  localparam int CTL_EN1_BIT = 1;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_SET_EN0 = 8'h01;
  localparam logic [7:0] CTL_SET_EN1 = 8'h02;
  localparam logic [7:0] CTL_CLR_EN0 = 8'hfe;
  localparam logic [7:0] CTL_CLR_EN1 = 8'hfd;
  // Source indices in priority order, highest first
  localparam int NSRC = 12;
  localparam int SRC_TRAP = 0;
  localparam int SRC_NMI = 1;
  localparam int SRC_EXT0 = 2;
  localparam int SRC_EXT1 = 3;
  localparam int SRC_EXT2 = 4;
  localparam int SRC_TMR0 = 5;
  localparam int SRC_TMR1 = 6;
  localparam int SRC_DMA0 = 7;
  localparam int SRC_DMA1 = 8;
  localparam int SRC_CSER = 9;
  localparam int SRC_SER0 = 10;
  localparam int SRC_SER1 = 11;
  // Vector table offsets
  localparam logic [7:0] level1_vector_entry = 8'h00;
  localparam logic [7:0] level2_vector_entry = 8'h02;
  localparam logic [7:0] timer0_vector_entry = 8'h04;
  localparam logic [7:0] timer1_vector_entry = 8'h06;
  localparam logic [7:0] dma0_vector_entry = 8'h08;
  localparam logic [7:0] dma1_vector_entry = 8'h0a;
  localparam logic [7:0] clocked_serial_vector_entry = 8'h0c;
  localparam logic [7:0] async_serial0_vector_entry = 8'h0e;
  localparam logic [7:0] async_serial1_vector_entry = 8'h10;
  // Fixed jump addresses
  localparam logic [15:0] power_fail_jump_entry = 16'h0066;
  localparam logic [15:0] TRAP_JUMP_ADDR = 16'h0000;
  localparam logic [15:0] EXT0_JUMP_ADDR = 16'h0038;
  localparam logic [3:0] SRC_NONE = 4'hf;

  typedef enum logic [1:0] {
    IVP_KIND_NONE = 2'b00,
    IVP_KIND_JUMP = 2'b01,
    IVP_KIND_TABLE = 2'b10
  } ivp_kind_e;

  // Answer handed to the processor core
  typedef struct packed {
    ivp_kind_e kind;
    logic [3:0] src;
    logic [7:0] table_offset;
    logic [15:0] jump_addr;
  } ivp_grant_s;
endpackage

// ==== core/ivp_sync.sv ====
// Two-stage synchroniser for one input level
`timescale 1ns/1ps
`default_nettype none
module ivp_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Level in and out
  input wire logic d,
  output logic q
);
  logic meta_r;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      meta_r <= RESET_VAL;
      q <= RESET_VAL;
    end else if (clk_en) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ==== core/ivp_top.sv ====
// Interrupt acceptance, priority and vector selection
`timescale 1ns/1ps
`default_nettype none
module ivp_top (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // External request pins, active low
  input wire logic ext_irq_level0_n,
  input wire logic ext_irq_level1_n,
  input wire logic ext_irq_level2_n,
  // Core-side event sources
  input wire logic trap_req,
  input wire logic nmi_pulse,
  input wire logic timer0_req,
  input wire logic timer1_req,
  input wire logic dma0_req,
  input wire logic dma1_req,
  input wire logic cser_req,
  input wire logic ser0_req,
  input wire logic ser1_req,
  // Core-side control register access
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  output logic [7:0] trap_irq_control_reg,
  // Acknowledge from the core
  input wire logic int_ack,
  // Answer to the core
  output logic irq_pending,
  output ivp_pkg::ivp_grant_s grant
);
  logic lvl0_n, lvl1_n, lvl2_n;
  logic nmi_latch_r;
  logic [ivp_pkg::NSRC-1:0] req;
  ivp_pkg::ivp_grant_s grant_nxt;
  logic nmi_ack;
  logic win_any;
  logic [3:0] win_idx;

  // Pins arrive from outside the clock domain
  ivp_sync #(.RESET_VAL(1'b1)) u_sync0 (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .d(ext_irq_level0_n),
    .q(lvl0_n)
  );
  ivp_sync #(.RESET_VAL(1'b1)) u_sync1 (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .d(ext_irq_level1_n),
    .q(lvl1_n)
  );
  ivp_sync #(.RESET_VAL(1'b1)) u_sync2 (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .d(ext_irq_level2_n),
    .q(lvl2_n)
  );

  // Control register, software does read-modify-write
  // Bits other than the two enables are kept but steer nothing
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      trap_irq_control_reg <= ivp_pkg::CTL_RESET;
    end else if (clk_en && ctl_wr) begin
      trap_irq_control_reg <= ctl_wdata;
    end
  end

  // The core acknowledges only the source it was shown
  assign nmi_ack = int_ack && grant.src == 4'(ivp_pkg::SRC_NMI);

  // NMI is an event; latched so a short pulse is not missed. Set beats ack-clear.
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      nmi_latch_r <= 1'b0;
    end else if (clk_en) begin
      if (nmi_pulse) begin
        nmi_latch_r <= 1'b1;
      end else if (nmi_ack) begin
        nmi_latch_r <= 1'b0;
      end
    end
  end

  // Levels are gated live, never stored, so a disabled request leaves no trace
  always_comb begin
    req = '0;
    req[ivp_pkg::SRC_TRAP] = trap_req;
    req[ivp_pkg::SRC_NMI] = nmi_latch_r;
    req[ivp_pkg::SRC_EXT0] = ~lvl0_n & trap_irq_control_reg[ivp_pkg::CTL_EN0_BIT];
    req[ivp_pkg::SRC_EXT1] = ~lvl1_n & trap_irq_control_reg[ivp_pkg::CTL_EN1_BIT];
    // Level 2 has no enable bit, so it is always live
    req[ivp_pkg::SRC_EXT2] = ~lvl2_n;
    req[ivp_pkg::SRC_TMR0] = timer0_req;
    req[ivp_pkg::SRC_TMR1] = timer1_req;
    req[ivp_pkg::SRC_DMA0] = dma0_req;
    req[ivp_pkg::SRC_DMA1] = dma1_req;
    req[ivp_pkg::SRC_CSER] = cser_req;
    req[ivp_pkg::SRC_SER0] = ser0_req;
    req[ivp_pkg::SRC_SER1] = ser1_req;
  end

  // Table entries sit two bytes apart in source order
  function automatic logic [7:0] table_of(input int s);
    unique case (s)
      ivp_pkg::SRC_EXT1: table_of = ivp_pkg::level1_vector_entry;
      ivp_pkg::SRC_EXT2: table_of = ivp_pkg::level2_vector_entry;
      ivp_pkg::SRC_TMR0: table_of = ivp_pkg::timer0_vector_entry;
      ivp_pkg::SRC_TMR1: table_of = ivp_pkg::timer1_vector_entry;
      ivp_pkg::SRC_DMA0: table_of = ivp_pkg::dma0_vector_entry;
      ivp_pkg::SRC_DMA1: table_of = ivp_pkg::dma1_vector_entry;
      ivp_pkg::SRC_CSER: table_of = ivp_pkg::clocked_serial_vector_entry;
      ivp_pkg::SRC_SER0: table_of = ivp_pkg::async_serial0_vector_entry;
      ivp_pkg::SRC_SER1: table_of = ivp_pkg::async_serial1_vector_entry;
      default: table_of = 8'h00;
    endcase
  endfunction

  // Trap, NMI and level 0 are jump-vectored; every other source uses the table
  function automatic ivp_pkg::ivp_kind_e kind_of(input int s);
    unique case (s)
      ivp_pkg::SRC_TRAP: kind_of = ivp_pkg::IVP_KIND_JUMP;
      ivp_pkg::SRC_NMI: kind_of = ivp_pkg::IVP_KIND_JUMP;
      ivp_pkg::SRC_EXT0: kind_of = ivp_pkg::IVP_KIND_JUMP;
      ivp_pkg::SRC_EXT1: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_EXT2: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_TMR0: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_TMR1: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_DMA0: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_DMA1: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_CSER: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_SER0: kind_of = ivp_pkg::IVP_KIND_TABLE;
      ivp_pkg::SRC_SER1: kind_of = ivp_pkg::IVP_KIND_TABLE;
      default: kind_of = ivp_pkg::IVP_KIND_NONE;
    endcase
  endfunction

  // Fixed jump addresses; table sources carry none, so the core never mixes the two
  function automatic logic [15:0] jump_of(input int s);
    unique case (s)
      ivp_pkg::SRC_TRAP: jump_of = ivp_pkg::TRAP_JUMP_ADDR;
      ivp_pkg::SRC_NMI: jump_of = ivp_pkg::power_fail_jump_entry;
      ivp_pkg::SRC_EXT0: jump_of = ivp_pkg::EXT0_JUMP_ADDR;
      ivp_pkg::SRC_EXT1: jump_of = 16'h0000;
      ivp_pkg::SRC_EXT2: jump_of = 16'h0000;
      ivp_pkg::SRC_TMR0: jump_of = 16'h0000;
      ivp_pkg::SRC_TMR1: jump_of = 16'h0000;
      ivp_pkg::SRC_DMA0: jump_of = 16'h0000;
      ivp_pkg::SRC_DMA1: jump_of = 16'h0000;
      ivp_pkg::SRC_CSER: jump_of = 16'h0000;
      ivp_pkg::SRC_SER0: jump_of = 16'h0000;
      ivp_pkg::SRC_SER1: jump_of = 16'h0000;
      default: jump_of = 16'h0000;
    endcase
  endfunction

  // Fixed priority: the lowest index that asks wins; the flag blocks later hits
  always_comb begin
    win_any = 1'b0;
    win_idx = ivp_pkg::SRC_NONE;
    for (int i = 0; i < ivp_pkg::NSRC; i++) begin
      if (req[i] && !win_any) begin
        win_any = 1'b1;
        win_idx = 4'(i);
      end
    end
  end

  // Answer fields follow from the winner alone
  always_comb begin
    grant_nxt.kind = ivp_pkg::IVP_KIND_NONE;
    grant_nxt.src = win_idx;
    grant_nxt.table_offset = 8'h00;
    grant_nxt.jump_addr = 16'h0000;
    if (win_any) begin
      grant_nxt.kind = kind_of(int'(win_idx));
      grant_nxt.table_offset = table_of(int'(win_idx));
      grant_nxt.jump_addr = jump_of(int'(win_idx));
    end
  end

  // Registered answer; updates each cycle that clk_en is high so a withdrawn level drops out
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      grant.kind <= ivp_pkg::IVP_KIND_NONE;
      grant.src <= ivp_pkg::SRC_NONE;
      grant.table_offset <= 8'h00;
      grant.jump_addr <= 16'h0000;
    end else if (clk_en) begin
      grant <= grant_nxt;
    end
  end

  // Pending flag, cheaper for the core to poll than decoding the answer
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      irq_pending <= 1'b0;
    end else if (clk_en) begin
      irq_pending <= |req;
    end
  end
endmodule
`default_nettype wire

// ==== test/ivp_ext_dev.sv ====
// Model of the devices on the external request pins
`timescale 1ns/1ps
`default_nettype none
module ivp_ext_dev (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Service wanted, levels 0 to 2
  input wire logic [2:0] want,
  // Request pins, pulled up when released
  output logic [2:0] pin_n
);
  // Follows want one clock later: held low while service is wanted, released when it drops
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) pin_n <= 3'h7;
    else pin_n <= ~want;
  end
endmodule
`default_nettype wire

// ==== test/ivp_properties.sv ====
// Checker for the interrupt vector and priority block
`timescale 1ns/1ps
`default_nettype none
module ivp_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Requests and control
  input wire logic trap_req,
  input wire logic nmi_pulse,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  // Answers
  input wire logic [7:0] trap_irq_control_reg,
  input wire ivp_pkg::ivp_grant_s grant
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  a_ctl_write: assert property (clk_en && ctl_wr |=> trap_irq_control_reg == $past(ctl_wdata))
    else $error("control write lost");
  a_nmi_jump: assert property (clk_en && nmi_pulse && !trap_req |-> ##[1:2] grant.src == 4'h1 && grant.jump_addr == 16'h0066)
    else $error("nmi not taken");
  a_trap_first: assert property (clk_en && trap_req |=> grant.src == 4'h0 && grant.kind == 2'h1)
    else $error("trap not first");
  a_ext0_jump: assert property (grant.src == 4'h2 |-> grant.kind == 2'h1 && grant.jump_addr == 16'h0038)
    else $error("level 0 not a jump");
  a_table_map: assert property (grant.kind == 2'h2 |-> grant.table_offset == {3'h0, grant.src - 4'h3, 1'b0})
    else $error("bad table offset");
  a_ser1_entry: assert property (grant.src == 4'hb |-> grant.kind == 2'h2 && grant.table_offset == 8'h10)
    else $error("serial 1 entry wrong");
  a_ext0_masked: assert property (!trap_irq_control_reg[0] && !$past(trap_irq_control_reg[0]) |-> grant.src != 4'h2)
    else $error("masked level 0 taken");
  a_ext1_masked: assert property (!trap_irq_control_reg[1] && !$past(trap_irq_control_reg[1]) |-> grant.src != 4'h3)
    else $error("masked level 1 taken");
endmodule
bind ivp_top ivp_properties u_chk (.core_clk(core_clk), .reset(reset), .clk_en(clk_en), .trap_req(trap_req),
  .nmi_pulse(nmi_pulse), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata), .trap_irq_control_reg(trap_irq_control_reg),
  .grant(grant));
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the interrupt vector and priority block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {int due; ivp_pkg::ivp_grant_s g;} ivp_note_s;
  logic core_clk = 0, reset = 1, ctl_wr = 0, int_ack = 0, nmi_pulse = 0, run = 1, irq_pending;
  logic [11:0] src = '0;
  logic [7:0] ctl_wdata = '0, en = '0, ctl_out;
  logic [2:0] pin_n;
  ivp_pkg::ivp_grant_s grant;
  ivp_note_s q[$];
  int cyc = 0, error_cnt = 0, cmp_count = 0, seed = 32'hcb19b8b1;
  logic [7:0] off_tab [9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h0e, 8'h10};
  initial forever #5 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  ivp_ext_dev dev (.core_clk(core_clk), .reset(reset), .want(src[4:2]), .pin_n(pin_n));
  ivp_top uut (.core_clk(core_clk), .reset(reset), .clk_en(run), .ext_irq_level0_n(pin_n[0]),
    .ext_irq_level1_n(pin_n[1]), .ext_irq_level2_n(pin_n[2]), .trap_req(src[0]), .nmi_pulse(nmi_pulse),
    .timer0_req(src[5]), .timer1_req(src[6]), .dma0_req(src[7]), .dma1_req(src[8]), .cser_req(src[9]),
    .ser0_req(src[10]), .ser1_req(src[11]), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .trap_irq_control_reg(ctl_out), .int_ack(int_ack), .irq_pending(irq_pending), .grant(grant));
  task automatic chk(input logic [29:0] seen, input logic [29:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("errors %0d, compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Lowest first so that the highest live source is written last
  function automatic ivp_pkg::ivp_grant_s pick(input logic [11:0] v, input logic [7:0] e);
    ivp_pkg::ivp_grant_s g;
    g = '{ivp_pkg::IVP_KIND_NONE, 4'hf, 8'h00, 16'h0000};
    for (int i = 11; i >= 0; i--) begin
      if (v[i] && !(i == 2 && !e[0]) && !(i == 3 && !e[1])) begin
        g.src = 4'(i);
        g.kind = i < 3 ? ivp_pkg::IVP_KIND_JUMP : ivp_pkg::IVP_KIND_TABLE;
        g.table_offset = i < 3 ? 8'h00 : off_tab[i - 3];
        g.jump_addr = i == 0 ? ivp_pkg::TRAP_JUMP_ADDR : ivp_pkg::EXT0_JUMP_ADDR;
        if (i == 1) g.jump_addr = ivp_pkg::power_fail_jump_entry;
      end
    end
    return g;
  endfunction
  // Fields that the answer's kind leaves unused are masked on both sides
  always @(negedge core_clk) begin
    ivp_pkg::ivp_grant_s g, e;
    ivp_note_s n;
    if (q.size() > 0 && q[0].due == cyc) begin
      g = grant;
      n = q.pop_front();
      e = n.g;
      if (e.kind != ivp_pkg::IVP_KIND_JUMP) {g.jump_addr, e.jump_addr} = '0;
      if (e.kind != ivp_pkg::IVP_KIND_TABLE) {g.table_offset, e.table_offset} = '0;
      chk(g, e);
      chk(irq_pending, e.kind != ivp_pkg::IVP_KIND_NONE);
    end
  end
  task automatic wr(input logic [7:0] d);
    @(posedge core_clk) #1;
    ctl_wr = 1;
    ctl_wdata = d;
    en = d;
    @(posedge core_clk) #1;
    ctl_wr = 0;
    chk(ctl_out, d);
  endtask
  // Hold long enough for the pin path, then release, and acknowledge only if the vector sent an NMI
  task automatic apply(input logic [11:0] v);
    @(posedge core_clk) #1;
    src = v & 12'hffd;
    nmi_pulse = v[1];
    q.push_back('{cyc + 5, pick(v, en)});
    @(posedge core_clk) #1 nmi_pulse = 0;
    repeat (5) @(posedge core_clk);
    #1 src = '0;
    @(posedge core_clk) #1 int_ack = v[1];
    @(posedge core_clk) #1 int_ack = 0;
    q.push_back('{cyc + 5, pick(12'h0, en)});
    repeat (6) @(posedge core_clk);
  endtask
  // A low enable must hold every register, so a live trap and level 2 show nothing
  task automatic freeze;
    @(posedge core_clk) #1;
    run = 0;
    src = 12'h011;
    q.push_back('{cyc + 3, pick(12'h0, en)});
    repeat (4) @(posedge core_clk);
    #1 src = '0;
    @(posedge core_clk) #1 run = 1;
    repeat (3) @(posedge core_clk);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    wrap_up;
  end
  initial begin
    repeat (10) @(posedge core_clk);
    #1 reset = 0;
    chk(ctl_out, ivp_pkg::CTL_RESET);
    wr(ivp_pkg::CTL_SET_EN0 | ivp_pkg::CTL_SET_EN1);
    for (int i = 0; i < 12; i++) apply(12'h1 << i);
    wr(en & ivp_pkg::CTL_CLR_EN1);
    apply(12'h008);
    wr(en | ivp_pkg::CTL_SET_EN1);
    apply(12'h000);
    wr(en & ivp_pkg::CTL_CLR_EN0);
    apply(12'h004);
    for (int i = 0; i < 24; i++) begin
      if (i % 4 == 0) wr(8'($random(seed)));
      apply(12'($random(seed)));
    end
    freeze;
    @(posedge core_clk) #1 reset = 1;
    @(posedge core_clk) #1 reset = 0;
    en = ivp_pkg::CTL_RESET;
    chk(ctl_out, ivp_pkg::CTL_RESET);
    apply(12'h004);
    wrap_up;
  end
endmodule
`default_nettype wire
